// ---- include/dibs_params.svh ----
// timing counts, register map and update-circuit codes of the dual image boot sequencer
`ifndef DIBS_PARAMS_SVH
`define DIBS_PARAMS_SVH

`define DIBS_CLK_HZ 100000000
`define DIBS_DWELL_MS 500
`define DIBS_HB_MS 50
`define DIBS_BLINK_MS 250
`define DIBS_APP_BLINK_S 7
`define DIBS_DWELL_CYC (`DIBS_DWELL_MS * (`DIBS_CLK_HZ / 1000))
`define DIBS_HB_CYC (`DIBS_HB_MS * (`DIBS_CLK_HZ / 1000))
`define DIBS_BLINK_CYC (`DIBS_BLINK_MS * (`DIBS_CLK_HZ / 1000))
`define DIBS_APP_CYC (`DIBS_APP_BLINK_S * `DIBS_CLK_HZ)

`define DIBS_APP_START_ADDR 32'h00400000
`define DIBS_PARAM_IMG_TYPE 3'h5
`define DIBS_PARAM_START_ADDR 3'h4
`define DIBS_PARAM_WDOG_EN 3'h3

`define DIBS_REG_CTRL 4'h0
`define DIBS_REG_STAT 4'h4
`define DIBS_CTRL_RESET 32'h00000001
`define DIBS_CTRL_RUN_BIT 0
`define DIBS_CTRL_RESTART_BIT 1
`define DIBS_STAT_HOLD_BIT 3
`define DIBS_STAT_APP_BIT 4
`define DIBS_STAT_RECONF_BIT 5

`endif

// ---- include/dibs_pkg.sv ----
// types shared by the dual image boot sequencer
package dibs_pkg;
    typedef enum logic [2:0] {
        DIBS_S0_RESET = 3'b000,
        DIBS_S1_RELEASE = 3'b001,
        DIBS_S2_IDLE = 3'b010,
        DIBS_S3_SEL_APP = 3'b011,
        DIBS_S4_LOAD_ADDR = 3'b100,
        DIBS_S5_WDOG_OFF = 3'b101,
        DIBS_S6_RECONFIG = 3'b110,
        DIBS_S7_HOLD = 3'b111
    } dibs_state_t;
endpackage

// ---- rtl/dibs_tick_div.sv ----
// cycle divider giving a one-cycle tick every DIV clocks
`timescale 1ns/100ps
module dibs_tick_div #(
    parameter int unsigned DIV = 4
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clr,
    output logic tick
);
    logic [31:0] cnt;
    wire wrap = (cnt == 32'(DIV - 1));
    wire [31:0] next_cnt = (clr || wrap) ? 32'h0 : cnt + 32'h1;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 32'h0;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= wrap && !clr;
        end
    end
endmodule

// ---- rtl/dibs_boot_seq.sv ----
// dual image boot sequencer: factory-image state machine, app-image blink and return
//
// Overview of operation
// - states 0 to 6 advance in ascending order; state 7 is a hold state
// - state 0 resets update circuit, state 1 releases it, state 2 idles
// - state 3 writes image type select as one, targeting the app image
// - state 4 writes the app image start address into the update circuit
// - that start address is the first address of sector 64
// - state 5 disables the update circuit watchdog before the app boots
// - entering state 6 drives the reconfiguration trigger high
// - low three leds show the current state number in binary, except state 7, which leaves them dark
// - fourth led toggles as a heartbeat, faster than the state steps
// - app image blinks three leds together 7 s, then returns to factory
// - hold state entered only on a detected error
// - hold state kept until an outside event; heartbeat keeps running
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "dibs_params.svh"
module dibs_boot_seq
    import dibs_pkg::*;
#(
    parameter int unsigned DWELL_CYCLES = `DIBS_DWELL_CYC,
    parameter int unsigned HB_CYCLES = `DIBS_HB_CYC,
    parameter int unsigned BLINK_CYCLES = `DIBS_BLINK_CYC,
    parameter int unsigned APP_CYCLES = `DIBS_APP_CYC,
    parameter int DATA_W = 32
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic ru_error,
    input wire logic app_image_running,
    output logic ru_reset,
    output logic ru_write,
    output logic [2:0] ru_param,
    output logic [DATA_W-1:0] ru_data,
    output logic ru_reconfig,
    output logic image_type_select,
    output logic [3:0] led
);
    dibs_state_t state;
    dibs_state_t next_state;
    logic run_en;
    logic [31:0] app_cnt;
    logic app_done;
    logic blink;
    wire dwell_tick;
    wire hb_tick;
    wire blink_tick;

    // register decode
    wire sel_ctrl = (reg_addr == `DIBS_REG_CTRL);
    wire sel_stat = (reg_addr == `DIBS_REG_STAT);
    wire ctrl_wr = reg_wr && sel_ctrl;
    wire restart_req = ctrl_wr && reg_wdata[`DIBS_CTRL_RESTART_BIT];
    wire next_run_en = ctrl_wr ? reg_wdata[`DIBS_CTRL_RUN_BIT] : run_en;
    wire in_hold = (state == DIBS_S7_HOLD);
    wire [31:0] stat_word = {26'h0, ru_reconfig, app_image_running, in_hold, state};
    wire [31:0] ctrl_word = {31'h0, run_en};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_word : (sel_stat ? stat_word : 32'h0);
    wire [31:0] next_rdata = reg_rd ? rd_mux : 32'h0;

    // sequencing
    wire entering = (next_state != state);
    wire adv = run_en && dwell_tick;

    // dwell restarts on every state change so each state stays a full period
    // held clear in the app phase so state 0 keeps its full reset time on return
    dibs_tick_div #(
        .DIV(DWELL_CYCLES)
    ) u_dwell (
        .mclk(mclk),
        .rstn(rstn),
        .clr(entering || app_image_running),
        .tick(dwell_tick)
    );

    dibs_tick_div #(
        .DIV(HB_CYCLES)
    ) u_heartbeat (
        .mclk(mclk),
        .rstn(rstn),
        .clr(1'b0),
        .tick(hb_tick)
    );

    dibs_tick_div #(
        .DIV(BLINK_CYCLES)
    ) u_blink (
        .mclk(mclk),
        .rstn(rstn),
        .clr(!app_image_running),
        .tick(blink_tick)
    );

    always_comb begin
        next_state = state;
        if (app_image_running) begin
            // factory logic parks at state 0 so a return restarts the cycle
            next_state = DIBS_S0_RESET;
        end else begin
            case (state)
                DIBS_S0_RESET: begin
                    if (ru_error) next_state = DIBS_S7_HOLD;
                    else if (adv) next_state = DIBS_S1_RELEASE;
                end
                DIBS_S1_RELEASE: begin
                    if (ru_error) next_state = DIBS_S7_HOLD;
                    else if (adv) next_state = DIBS_S2_IDLE;
                end
                DIBS_S2_IDLE: begin
                    if (ru_error) next_state = DIBS_S7_HOLD;
                    else if (adv) next_state = DIBS_S3_SEL_APP;
                end
                DIBS_S3_SEL_APP: begin
                    if (ru_error) next_state = DIBS_S7_HOLD;
                    else if (adv) next_state = DIBS_S4_LOAD_ADDR;
                end
                DIBS_S4_LOAD_ADDR: begin
                    if (ru_error) next_state = DIBS_S7_HOLD;
                    else if (adv) next_state = DIBS_S5_WDOG_OFF;
                end
                DIBS_S5_WDOG_OFF: begin
                    if (ru_error) next_state = DIBS_S7_HOLD;
                    else if (adv) next_state = DIBS_S6_RECONFIG;
                end
                DIBS_S6_RECONFIG: begin
                    // stays here until the loaded app image takes over
                    if (ru_error) next_state = DIBS_S7_HOLD;
                end
                DIBS_S7_HOLD: begin
                    // only a software restart, or the app image starting, leaves the hold
                    if (restart_req) next_state = DIBS_S0_RESET;
                end
                default: next_state = DIBS_S7_HOLD;
            endcase
        end
    end

    // update circuit parameter writes on entry to states 3, 4 and 5
    wire wr_sel = (next_state == DIBS_S3_SEL_APP);
    wire wr_addr = (next_state == DIBS_S4_LOAD_ADDR);
    wire wr_wdog = (next_state == DIBS_S5_WDOG_OFF);
    wire next_write = entering && (wr_sel || wr_addr || wr_wdog);
    wire [2:0] wr_param = wr_sel ? `DIBS_PARAM_IMG_TYPE :
                          (wr_addr ? `DIBS_PARAM_START_ADDR : `DIBS_PARAM_WDOG_EN);
    // watchdog enable is written as zero
    wire [DATA_W-1:0] wr_data = wr_sel ? DATA_W'(1) :
                                (wr_addr ? DATA_W'(`DIBS_APP_START_ADDR) : '0);
    wire next_ru_reset = (next_state == DIBS_S0_RESET) && !app_image_running;

    // app image phase
    wire app_last = (app_cnt == 32'(APP_CYCLES - 1));
    wire next_app_done = app_image_running && (app_done || app_last);
    wire [31:0] next_app_cnt = (!app_image_running || app_done) ? 32'h0 : app_cnt + 32'h1;
    wire next_blink = app_image_running && (blink_tick ? !blink : blink);
    wire next_reconfig = ((next_state == DIBS_S6_RECONFIG) && !app_image_running) ||
                         next_app_done;
    // image type falls back to factory once the app has shown itself
    wire next_img_sel = next_app_done ? 1'b0 :
                        (entering && wr_sel) ? 1'b1 :
                        (next_ru_reset ? 1'b0 : image_type_select);
    // hold shows only the heartbeat; low leds dark
    wire [2:0] state_leds = (next_state == DIBS_S7_HOLD) ? 3'h0 : next_state;
    wire [2:0] next_low_led = app_image_running ? {3{next_blink}} : state_leds;
    wire next_hb = app_image_running ? 1'b0 : (hb_tick ? !led[3] : led[3]);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= DIBS_S0_RESET;
            run_en <= 1'b1;
            reg_rdata <= 32'h0;
        end else begin
            state <= next_state;
            run_en <= next_run_en;
            reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ru_reset <= 1'b1;
            ru_write <= 1'b0;
            ru_param <= 3'h0;
            ru_data <= '0;
        end else begin
            ru_reset <= next_ru_reset;
            ru_write <= next_write;
            ru_param <= wr_param;
            ru_data <= wr_data;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ru_reconfig <= 1'b0;
            image_type_select <= 1'b0;
            app_cnt <= 32'h0;
            app_done <= 1'b0;
            blink <= 1'b0;
            led <= 4'h0;
        end else begin
            ru_reconfig <= next_reconfig;
            image_type_select <= next_img_sel;
            app_cnt <= next_app_cnt;
            app_done <= next_app_done;
            blink <= next_blink;
            led <= {next_hb, next_low_led};
        end
    end

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    a_led_state_show: assert property (
        (!app_image_running && !$past(app_image_running) && state != DIBS_S7_HOLD)
            |-> (led[2:0] == state))
        else $error("low leds do not show the state");

    a_reset_in_s0: assert property (
        (!$past(app_image_running) && state == DIBS_S0_RESET) |-> ru_reset ##0
            (state != DIBS_S1_RELEASE || !ru_reset))
        else $error("update circuit reset wrong in state 0");

    a_reset_release: assert property (
        (state == DIBS_S1_RELEASE) |-> !ru_reset)
        else $error("update circuit reset not released");

    a_step_order: assert property (
        ($past(state) != DIBS_S7_HOLD && state != DIBS_S7_HOLD &&
         state != $past(state) && !$past(app_image_running))
            |-> (state == dibs_state_t'($past(state) + 3'h1)))
        else $error("state skipped or went backwards");

    a_hold_on_error: assert property (
        (state != DIBS_S7_HOLD ##1 state == DIBS_S7_HOLD) |-> $past(ru_error))
        else $error("hold entered without an error");

    a_hold_sticky: assert property (
        (in_hold && !restart_req && !app_image_running) |=> in_hold)
        else $error("hold left without an outside event");

    a_img_sel_write: assert property (
        ($past(state) == DIBS_S2_IDLE && state == DIBS_S3_SEL_APP)
            |-> (ru_write && ru_param == `DIBS_PARAM_IMG_TYPE && ru_data == DATA_W'(1)
                 && image_type_select))
        else $error("image type write missing in state 3");

    a_addr_write: assert property (
        ($past(state) == DIBS_S3_SEL_APP && state == DIBS_S4_LOAD_ADDR)
            |-> (ru_write && ru_param == `DIBS_PARAM_START_ADDR &&
                 ru_data == DATA_W'(`DIBS_APP_START_ADDR)))
        else $error("start address write missing in state 4");

    a_wdog_write: assert property (
        ($past(state) == DIBS_S4_LOAD_ADDR && state == DIBS_S5_WDOG_OFF)
            |-> (ru_write && ru_param == `DIBS_PARAM_WDOG_EN && ru_data == '0)
            ##1 !ru_write)
        else $error("watchdog disable write missing in state 5");

    a_reconfig_s6: assert property (
        (state == DIBS_S6_RECONFIG && !$past(app_image_running)) |-> ru_reconfig)
        else $error("reconfig trigger low in state 6");

    a_heartbeat_toggle: assert property (
        (hb_tick && !app_image_running) |=> (led[3] != $past(led[3])))
        else $error("heartbeat did not toggle");

    a_app_blink_together: assert property (
        ($past(app_image_running) && app_image_running)
            |-> (led[2:0] == 3'h0 || led[2:0] == 3'h7))
        else $error("app leds not blinking together");

    a_app_return: assert property (
        (app_image_running && app_last && !app_done)
            |=> (ru_reconfig && !image_type_select))
        else $error("app did not request factory return");

    a_hold_leds_dark: assert property (
        in_hold |-> (led[2:0] == 3'h0))
        else $error("low leds lit in hold");

    a_reconfig_only: assert property (
        ru_reconfig |-> (state == DIBS_S6_RECONFIG || app_done))
        else $error("reconfig trigger outside state 6 or app return");

    a_app_no_reset: assert property (
        (app_image_running && $past(app_image_running)) |-> !ru_reset)
        else $error("update circuit held in reset while app runs");

    a_write_one_cycle: assert property (
        ru_write |=> !ru_write)
        else $error("parameter write longer than one cycle");

    a_img_sel_reset: assert property (
        (state == DIBS_S0_RESET && !$past(app_image_running)) |-> !image_type_select)
        else $error("image type select not cleared in state 0");

    a_run_frozen: assert property (
        (!$past(run_en) && !$past(ru_error) && !$past(app_image_running) &&
         $past(state) != DIBS_S7_HOLD) |-> (state == $past(state)))
        else $error("state moved while stepping was stopped");

    c_reach_reconfig: cover property (
        state == DIBS_S5_WDOG_OFF ##1 state == DIBS_S6_RECONFIG);
    c_reach_hold: cover property (state != DIBS_S7_HOLD ##1 state == DIBS_S7_HOLD);
    c_hold_restart: cover property (in_hold && restart_req ##1 state == DIBS_S0_RESET);
    c_app_return: cover property (app_image_running && app_done && ru_reconfig);
    c_run_frozen: cover property (!run_en && dwell_tick && state == DIBS_S0_RESET);
endmodule

// ---- bench/dibs_ru_partner.sv ----
// behavioural model of the remote update circuit on the far side of the sequencer
`timescale 1ns/100ps
`include "dibs_params.svh"
module dibs_ru_partner (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ru_reset,
    input wire logic ru_write,
    input wire logic [2:0] ru_param,
    input wire logic [31:0] ru_data,
    input wire logic ru_reconfig,
    input wire logic err_req,
    input wire logic [7:0] boot_delay,
    output logic ru_error,
    output logic app_image_running
);
    logic img;
    logic wdog;
    logic [31:0] addr;
    logic [7:0] wait_cnt;
    // a real loader refuses to boot a wrongly set up image, so the model does too
    wire boot_ok = img && addr == `DIBS_APP_START_ADDR && !wdog;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            {img, wdog, addr, wait_cnt, ru_error, app_image_running} <= '0;
        end else begin
            ru_error <= err_req;
            if (ru_reset) begin
                {img, wdog, addr} <= {1'b0, 1'b1, 32'h0};
            end else if (ru_write) begin
                if (ru_param == `DIBS_PARAM_IMG_TYPE) img <= ru_data[0];
                if (ru_param == `DIBS_PARAM_START_ADDR) addr <= ru_data;
                if (ru_param == `DIBS_PARAM_WDOG_EN) wdog <= ru_data[0];
            end
            wait_cnt <= ru_reconfig ? wait_cnt + 8'h1 : 8'h0;
            if (ru_reconfig && wait_cnt == boot_delay) begin
                app_image_running <= !app_image_running && boot_ok;
            end
        end
    end
endmodule

// ---- bench/dibs_boot_seq_tb.sv ----
// self-checking bench for the dual image boot sequencer
`timescale 1ns/100ps
`include "dibs_params.svh"
module dibs_boot_seq_tb;
    localparam int DW = 8;
    localparam int APP = 40;
    localparam int BL = 3;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic err_req = 1'b0;
    logic [7:0] boot_delay = 8'h3;
    logic [31:0] reg_rdata, ru_data;
    logic [31:0] seed = 32'hc9f2573a;
    logic ru_error, app_image_running, ru_reset, ru_write, ru_reconfig, image_type_select;
    logic [2:0] ru_param;
    logic [3:0] led;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    int wcount = 0;
    int n, hb, tg, ws;
    int wexp = 3;
    logic rd_hold = 1'b0;

    always #5 mclk = ~mclk;

    dibs_boot_seq #(.DWELL_CYCLES(DW), .HB_CYCLES(2), .BLINK_CYCLES(BL), .APP_CYCLES(APP))
    u_dibs_boot_seq (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ru_error(ru_error),
        .app_image_running(app_image_running), .ru_reset(ru_reset), .ru_write(ru_write),
        .ru_param(ru_param), .ru_data(ru_data), .ru_reconfig(ru_reconfig),
        .image_type_select(image_type_select), .led(led));

    dibs_ru_partner u_dibs_ru_partner (.mclk(mclk), .rstn(rstn), .ru_reset(ru_reset),
        .ru_write(ru_write), .ru_param(ru_param), .ru_data(ru_data), .ru_reconfig(ru_reconfig),
        .err_req(err_req), .boot_delay(boot_delay), .ru_error(ru_error),
        .app_image_running(app_image_running));

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction

    task automatic test_done;
        if (bad_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // whole run needs about 600 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            chk(32'h0, 32'h1, "timeout");
            test_done();
        end
    end

    // parameter writes are checked against the state that issued them
    // read data must be zero in every cycle that does not follow a read strobe
    always @(negedge mclk) begin
        if (rd_hold === 1'b0) chk(reg_rdata, 32'h0, "rdata idle");
        rd_hold = reg_rd;
        if (ru_write === 1'b1) begin
            wcount++;
            ws = led[2:0];
            chk(ws >= 3 && ws <= 5, 1, "write state");
            chk(ru_param, ws == 3 ? `DIBS_PARAM_IMG_TYPE : ws == 4 ? `DIBS_PARAM_START_ADDR :
                `DIBS_PARAM_WDOG_EN, "param");
            chk(ru_data, ws == 3 ? 1 : ws == 4 ? `DIBS_APP_START_ADDR : 0, "data");
        end
    end

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input string w);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e, w);
    endtask

    // waits for the state leds to move, counting cycles and heartbeat toggles
    task automatic step(output int cnt, output int hbt);
        logic [2:0] s0;
        logic h;
        s0 = led[2:0];
        h = led[3];
        cnt = 0;
        hbt = 0;
        while (led[2:0] === s0 && cnt < 100) begin
            @(negedge mclk);
            cnt++;
            if (led[3] !== h) hbt++;
            h = led[3];
        end
    endtask

    task automatic run_seq;
        for (int s = 1; s <= 6; s++) begin
            step(n, hb);
            chk(led[2:0], s, "state");
            chk(ru_reset, 0, "ru reset");
            chk(image_type_select, s >= 3, "image select");
            chk(ru_reconfig, s == 6, "reconfig");
            if (s >= 2) chk(n >= DW && n <= DW + 2, 1, "dwell");
            if (s >= 2) chk(hb >= 2, 1, "heartbeat");
        end
    endtask

    task automatic app_phase;
        int bl;
        logic b;
        n = 0;
        while (app_image_running !== 1'b1 && n < 300) begin
            @(negedge mclk);
            n++;
        end
        repeat (2) @(negedge mclk);
        n = 0;
        bl = 0;
        b = led[0];
        while (ru_reconfig !== 1'b1 && n < 200) begin
            chk(led, {1'b0, {3{led[0]}}}, "app leds");
            if (led[0] !== b) bl++;
            b = led[0];
            @(negedge mclk);
            n++;
        end
        chk(n >= APP - 3 && n <= APP + 3, 1, "app time");
        chk(bl >= APP / BL - 2, 1, "blink count");
        chk(image_type_select, 0, "image select app");
        n = 0;
        while (app_image_running !== 1'b0 && n < 300) begin
            @(negedge mclk);
            n++;
        end
        repeat (2) @(negedge mclk);
        chk({ru_reset, led[2:0]}, 4'h8, "back to factory");
        chk(led[3], 1, "heartbeat back");
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        @(negedge mclk);
        chk({ru_reset, ru_reconfig, image_type_select, led[2:0]}, 6'h20, "reset");
        wr(4'h8, 32'hffffffff);
        rd_chk(`DIBS_REG_CTRL, `DIBS_CTRL_RESET, "ctrl reset");
        rd_chk(4'h8, 0, "unmapped");
        wr(`DIBS_REG_CTRL, 0);
        repeat (3 * DW) @(negedge mclk);
        chk(led[2:0], 0, "frozen");
        rd_chk(`DIBS_REG_STAT, 0, "status idle");
        wr(`DIBS_REG_CTRL, 1);
        run_seq();
        app_phase();
        for (int k = 0; k < 2; k++) begin
            seed = xs(seed);
            tg = int'(seed[15:8] % 8'd6);
            n = 0;
            while (led[2:0] !== tg[2:0] && n < 100) begin
                @(negedge mclk);
                n++;
            end
            @(posedge mclk);
            err_req <= 1'b1;
            boot_delay <= seed[7:0] & 8'h1f;
            @(posedge mclk);
            err_req <= 1'b0;
            rd_chk(`DIBS_REG_STAT, 32'hf, "hold");
            step(n, hb);
            chk({n[28:0], led[2:0]}, {29'd100, 3'h0}, "hold kept");
            chk(hb >= 20, 1, "hold heartbeat");
            wr(`DIBS_REG_CTRL, 32'h3);
            rd_chk(`DIBS_REG_CTRL, 1, "ctrl restart");
            rd_chk(`DIBS_REG_STAT, 0, "restart state");
            run_seq();
            app_phase();
            // states 3 to tg were entered, and written, before the error struck
            wexp += (tg > 2 ? tg - 2 : 0) + 3;
            chk(wcount, wexp, "write count");
        end
        test_done();
    end
endmodule
